// ---- common/tsp_pkg.sv ----
`default_nettype none
package tsp_pkg;

  // Register indices and byte addresses on the bus
  localparam logic [7:0] TC_INDEX  = 8'h01;
  localparam logic [7:0] SET_INDEX = 8'h02;
  localparam logic [7:0] DIR_INDEX = 8'h03;
  localparam logic [7:0] CMD_INDEX = 8'h04;
  localparam logic [7:0] TC_ADDR   = {TC_INDEX[5:0], 2'h0};
  localparam logic [7:0] SET_ADDR  = {SET_INDEX[5:0], 2'h0};
  localparam logic [7:0] DIR_ADDR  = {DIR_INDEX[5:0], 2'h0};
  localparam logic [7:0] CMD_ADDR  = {CMD_INDEX[5:0], 2'h0};

  // Reset values
  localparam logic [7:0] SET_RESET = 8'hFF;
  localparam logic [5:0] DIR_RESET = 6'h3F;
  localparam logic [7:0] TC_RESET  = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // Field positions
  localparam int unsigned CMD_WDT_CLR_BIT = 0;
  localparam int unsigned COUNT_PIN_BIT   = 2;
  localparam int unsigned PIN_COUNT       = 6;

  // Timing counts in instruction cycles and oscillator phases
  localparam logic [1:0] INHIBIT_CYCLES = 2'h2;
  localparam logic [1:0] PH_TWO         = 2'h1;
  localparam logic [1:0] PH_FOUR        = 2'h3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Setup register layout, bit 7 down to bit 0
  typedef struct packed {
    logic       wake_en;
    logic       pull_en;
    logic       clock_source_sel;
    logic       edge_sel;
    logic       divider_assign;
    logic [2:0] ratio_sel;
  } tsp_setup_s;

endpackage : tsp_pkg
`default_nettype wire

// ---- core/tsp_divider.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsp_divider (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Control
  input  wire logic       clear,
  input  wire logic       advance,
  input  wire logic [2:0] ratio_sel,
  // Divided outputs
  output var  logic       level,
  output var  logic       tmr_tick,
  output var  logic       wdt_tick
);

  logic [7:0] cnt_reg;

  // Mask of the n lowest bits
  function automatic logic [7:0] low_ones(input logic [3:0] n);
    logic [8:0] m;
    m = (9'h001 << n) - 9'h001;
    return m[7:0];
  endfunction : low_ones

  // Counter cleared by reset or by owner event, else advances
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
      cnt_reg <= tsp_pkg::DIV_RESET;
    else if (advance)
      cnt_reg <= cnt_reg + 8'h01;
  end

  // Symmetric level and terminal-count pulses
  always_comb
  begin
    level    = cnt_reg[ratio_sel];
    tmr_tick = advance && !clear &&
               ((cnt_reg & low_ones({1'b0, ratio_sel} + 4'h1)) ==
                low_ones({1'b0, ratio_sel} + 4'h1));
    wdt_tick = advance && !clear &&
               ((cnt_reg & low_ones({1'b0, ratio_sel})) ==
                low_ones({1'b0, ratio_sel}));
  end

  clear_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    clear |=> cnt_reg == tsp_pkg::DIV_RESET)
    else $error("divider not zero after clear");

  advance_step_a: assert property (@(posedge aclk) disable iff (!aresetn)
    advance && !clear |=> cnt_reg == $past(cnt_reg) + 8'h01)
    else $error("divider failed to advance");

endmodule : tsp_divider
`default_nettype wire

// ---- core/tsp_phase.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsp_phase (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Phase strobes
  output var  logic phase_two,
  output var  logic phase_four
);

  logic [1:0] ph_reg;

  // Four oscillator phases per instruction cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ph_reg <= 2'h0;
    else
      ph_reg <= ph_reg + 2'h1;
  end

  // One-clock strobes on the second and fourth phase
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      phase_two  <= 1'b0;
      phase_four <= 1'b0;
    end
    else
    begin
      phase_two  <= (ph_reg == tsp_pkg::PH_TWO);
      phase_four <= (ph_reg == tsp_pkg::PH_FOUR);
    end
  end

  phase_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
    phase_four |-> ##2 phase_two ##2 phase_four)
    else $error("phase strobes not four clocks apart");

endmodule : tsp_phase
`default_nettype wire

// ---- core/tsp_timer.sv ----
// Design decision made here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module tsp_timer (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output var  logic        s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output var  logic        s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]  s_axi_bresp,
  output var  logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output var  logic        s_axi_arready,
  // AXI4-Lite read data
  output var  logic [31:0] s_axi_rdata,
  output var  logic [1:0]  s_axi_rresp,
  output var  logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Pins
  input  wire logic        count_input_pin,
  output var  logic [5:0]  pin_out_en,
  // Watchdog side
  input  wire logic        wdt_osc_tick,
  output var  logic        wdt_clear_out,
  output var  logic        wdt_tick_out
);

  tsp_pkg::tsp_setup_s timer_setup_reg;
  logic [5:0]  pin_direction_reg;
  logic [7:0]  timer_count_reg;
  logic [1:0]  inhibit_reg;
  logic        pin_prev_reg;
  logic        samp_reg;
  logic        aw_full_reg;
  logic        w_full_reg;
  logic [7:0]  aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0]  w_strb_reg;
  logic        phase_two;
  logic        phase_four;
  logic        cyc_end;
  logic        sample;
  logic        ext;
  logic        to_tmr;
  logic        pin_q;
  logic        pin_rise;
  logic        pre_out;
  logic        inc_ext;
  logic        inc_int;
  logic        inc;
  logic        wr_fire;
  logic        lane0;
  logic        tc_write;
  logic        wdt_clr_cmd;
  logic        div_clear;
  logic        div_advance;
  logic        div_level;
  logic        div_tmr_tick;
  logic        div_wdt_tick;

  // Instruction cycle phase strobes
  tsp_phase u_phase (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .phase_two  (phase_two),
    .phase_four (phase_four)
  );

  // Shared divider, not visible to software
  tsp_divider u_div (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .clear     (div_clear),
    .advance   (div_advance),
    .ratio_sel (timer_setup_reg.ratio_sel),
    .level     (div_level),
    .tmr_tick  (div_tmr_tick),
    .wdt_tick  (div_wdt_tick)
  );

  // Mode decode and write strobes
  always_comb
  begin
    cyc_end     = phase_four;
    sample      = phase_two || phase_four;
    ext         = timer_setup_reg.clock_source_sel;
    to_tmr      = !timer_setup_reg.divider_assign;
    pin_q       = count_input_pin ^ timer_setup_reg.edge_sel;
    pin_rise    = pin_q && !pin_prev_reg;
    wr_fire     = aw_full_reg && w_full_reg && !s_axi_bvalid;
    lane0       = w_strb_reg[0];
    tc_write    = wr_fire && lane0 && (aw_addr_reg == tsp_pkg::TC_ADDR);
    wdt_clr_cmd = wr_fire && lane0 && (aw_addr_reg == tsp_pkg::CMD_ADDR) &&
                  w_data_reg[tsp_pkg::CMD_WDT_CLR_BIT];
  end

  // Divider owner selects what advances and clears it
  always_comb
  begin
    div_clear   = to_tmr ? tc_write : wdt_clr_cmd;
    if (to_tmr)
      div_advance = ext ? pin_rise : cyc_end;
    else
      div_advance = wdt_osc_tick;
    pre_out     = to_tmr ? div_level : pin_q;
  end

  // Increment sources and write stall
  always_comb
  begin
    inc_ext = sample && pre_out && !samp_reg;
    inc_int = cyc_end && (to_tmr ? div_tmr_tick : 1'b1);
    inc     = (ext ? inc_ext : inc_int) && (inhibit_reg == 2'h0);
  end

  // Pin history for edge detection
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_prev_reg <= 1'b1; // No false rise after reset
    else
      pin_prev_reg <= pin_q;
  end

  // Synchroniser sampling on phase two and four
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      samp_reg <= 1'b1; // Idle level never counts as an edge
    else if (sample)
      samp_reg <= pre_out;
  end

  // Write stall lasting two instruction cycles
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      inhibit_reg <= 2'h0;
    else if (tc_write)
      inhibit_reg <= tsp_pkg::INHIBIT_CYCLES;
    else if (cyc_end && inhibit_reg != 2'h0)
      inhibit_reg <= inhibit_reg - 2'h1;
  end

  // Count register, write wins over increment
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      timer_count_reg <= tsp_pkg::TC_RESET;
    else if (tc_write)
      timer_count_reg <= w_data_reg[7:0];
    else if (inc)
      timer_count_reg <= timer_count_reg + 8'h01;
  end

  // Setup and direction registers, write only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      timer_setup_reg   <= tsp_pkg::SET_RESET;
      pin_direction_reg <= tsp_pkg::DIR_RESET;
    end
    else if (wr_fire && lane0)
    begin
      if (aw_addr_reg == tsp_pkg::SET_ADDR)
        timer_setup_reg <= w_data_reg[7:0];
      if (aw_addr_reg == tsp_pkg::DIR_ADDR)
        pin_direction_reg <= w_data_reg[5:0];
    end
  end

  // Pin drivers, count pin forced to input in external mode
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pin_out_en <= ~tsp_pkg::DIR_RESET;
    else
    begin
      pin_out_en <= ~pin_direction_reg;
      if (ext)
        pin_out_en[tsp_pkg::COUNT_PIN_BIT] <= 1'b0;
    end
  end

  // Watchdog clear pulse and postscaled tick
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wdt_clear_out <= 1'b0;
      wdt_tick_out  <= 1'b0;
    end
    else
    begin
      wdt_clear_out <= wdt_clr_cmd;
      wdt_tick_out  <= to_tmr ? wdt_osc_tick : div_wdt_tick;
    end
  end

  // Write address and data capture, either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_reg   <= 1'b0;
      s_axi_awready <= 1'b1;
      aw_addr_reg   <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_reg   <= 1'b1;
      s_axi_awready <= 1'b0;
      aw_addr_reg   <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_full_reg   <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_awready <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_reg   <= 1'b0;
      s_axi_wready <= 1'b1;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_reg   <= 1'b1;
      s_axi_wready <= 1'b0;
      w_data_reg   <= s_axi_wdata;
      w_strb_reg   <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_full_reg   <= 1'b0;
    else if (s_axi_bvalid && s_axi_bready)
      s_axi_wready <= 1'b1;
  end

  // Write response once both halves are in
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= tsp_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      case (aw_addr_reg)
        tsp_pkg::TC_ADDR,
        tsp_pkg::SET_ADDR,
        tsp_pkg::DIR_ADDR,
        tsp_pkg::CMD_ADDR: s_axi_bresp <= tsp_pkg::RESP_OKAY;
        default:           s_axi_bresp <= tsp_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // Read channel; write-only registers read zero
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tsp_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= tsp_pkg::RESP_OKAY;
      case (s_axi_araddr)
        tsp_pkg::TC_ADDR:  s_axi_rdata <= {24'h00_0000, timer_count_reg};
        tsp_pkg::SET_ADDR,
        tsp_pkg::DIR_ADDR,
        tsp_pkg::CMD_ADDR: s_axi_rdata <= 32'h0000_0000;
        default:           s_axi_rresp <= tsp_pkg::RESP_SLVERR;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  count_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    inc && !tc_write && timer_count_reg == 8'hFF |=> timer_count_reg == 8'h00)
    else $error("count did not wrap to zero");

  write_stall_a: assert property (@(posedge aclk) disable iff (!aresetn)
    tc_write ##1 (!tc_write)[*3] |-> $stable(timer_count_reg))
    else $error("count moved right after a write");

  cycle_rate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !ext && !to_tmr && cyc_end && inhibit_reg == 2'h0 && !tc_write
    |=> timer_count_reg == $past(timer_count_reg) + 8'h01)
    else $error("internal count missed a cycle");

  pin_forced_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ext |=> !pin_out_en[tsp_pkg::COUNT_PIN_BIT])
    else $error("count pin driven in external mode");

  sync_edge_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(ext) && !$past(tc_write) && timer_count_reg != $past(timer_count_reg)
    |-> $past(sample) && samp_reg && !$past(samp_reg))
    else $error("external increment without synchronised edge");

  wdt_undivided_a: assert property (@(posedge aclk) disable iff (!aresetn)
    to_tmr && wdt_osc_tick |=> wdt_tick_out)
    else $error("watchdog tick lost while undivided");

  tmr_divided_a: assert property (@(posedge aclk) disable iff (!aresetn)
    to_tmr && !ext && cyc_end && !div_tmr_tick && !tc_write |=> $stable(timer_count_reg))
    else $error("timer counted between divider terminal counts");

  read_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && s_axi_arready && s_axi_araddr == tsp_pkg::TC_ADDR
    |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(timer_count_reg))
    else $error("count read returned wrong value");

  bresp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");

endmodule : tsp_timer
`default_nettype wire

// ---- testbench/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // Bench signals
  logic        aclk;
  logic        aresetn;
  logic [7:0]  s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [7:0]  s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        count_input_pin;
  logic [5:0]  pin_out_en;
  logic        wdt_osc_tick;
  logic        wdt_clear_out;
  logic        wdt_tick_out;
  int          error_cnt;
  int          n_checks;
  int          cyc;
  int          n_tick;
  int          n_clr;
  logic [33:0] rq[$];
  logic [1:0]  bq[$];

  // Device and pulse source
  tsp_timer u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .count_input_pin,
    .pin_out_en, .wdt_osc_tick, .wdt_clear_out, .wdt_tick_out);
  tsp_src u_src (.aclk, .pin(count_input_pin), .osc(wdt_osc_tick));

  // Clock
  initial aclk = 1'b0;
  always #10 aclk = ~aclk;

  task automatic chk_val(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_val

  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test

  function automatic logic [33:0] ok(input logic [7:0] v);
    return {tsp_pkg::RESP_OKAY, 24'h0, v};
  endfunction : ok

  // Result monitor takes the oldest note
  always @(posedge aclk)
  begin
    if (s_axi_bvalid === 1'b1 && s_axi_bready)
      chk_val("bresp", {32'h0, bq.pop_front()}, {32'h0, s_axi_bresp});
    if (s_axi_rvalid === 1'b1 && s_axi_rready)
      chk_val("rresp,rdata", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
  end

  // Edge and pulse counters
  always @(posedge aclk)
  begin
    cyc    <= aresetn ? cyc + 1 : 0;
    n_tick <= n_tick + int'(wdt_tick_out === 1'b1);
    n_clr  <= n_clr + int'(wdt_clear_out === 1'b1);
  end

  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw_done;
    logic w_done;
    bq.push_back(r);
    aw_done       = 1'b0;
    w_done        = 1'b0;
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge aclk);
      if (!aw_done && s_axi_awready === 1'b1)
      begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1)
      begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  // Bus read
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
      @(posedge aclk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Drive from edge number t after release
  task automatic at(input int t);
    while (cyc + 1 != t) @(posedge aclk);
  endtask : at

  // Watchdog against hangs
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    end_of_test();
  end

  // Main sequence
  initial
  begin
    int          b;
    int          n0;
    logic [31:0] d;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    aresetn     = 1'b0;
    b = $urandom(75380);
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk_val("pin_out_en", 34'h0, 34'(pin_out_en));
    rd(tsp_pkg::TC_ADDR, ok(tsp_pkg::TC_RESET));
    rd(tsp_pkg::SET_ADDR, ok(8'h00));
    rd(8'h40, {tsp_pkg::RESP_SLVERR, 32'h0});
    wr(8'h40, 32'hFF, tsp_pkg::RESP_SLVERR);
    // Count pin stays input while external mode is set
    wr(tsp_pkg::DIR_ADDR, 32'h0, tsp_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val("pin_out_en", 34'h3B, 34'(pin_out_en));
    wr(tsp_pkg::SET_ADDR, 32'h08, tsp_pkg::RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk_val("pin_out_en", 34'h3F, 34'(pin_out_en));
    // Internal count: write lands on a strobe edge; it and two more are lost
    b = ((cyc + 1) / 4 + 2) * 4 + 3;
    at(b);
    wr(tsp_pkg::TC_ADDR, 32'hFE, tsp_pkg::RESP_OKAY);
    for (int k = 5; k <= 17; k += 4)
    begin
      at(b + 1 + k);
      rd(tsp_pkg::TC_ADDR, ok(8'hFE + 8'(k / 4 > 2 ? k / 4 - 2 : 0)));
    end
    // External rising edges, random loads read back
    wr(tsp_pkg::SET_ADDR, 32'h28, tsp_pkg::RESP_OKAY);
    repeat (3)
    begin
      d = $urandom;
      s_axi_wstrb <= 4'(d[31:28]) | 4'h1;
      wr(tsp_pkg::TC_ADDR, d, tsp_pkg::RESP_OKAY);
      rd(tsp_pkg::TC_ADDR, ok(d[7:0]));
      // Low byte lane off: write has no effect
      s_axi_wstrb <= 4'hE;
      wr(tsp_pkg::TC_ADDR, ~d, tsp_pkg::RESP_OKAY);
      rd(tsp_pkg::TC_ADDR, ok(d[7:0]));
    end
    s_axi_wstrb <= 4'hF;
    wr(tsp_pkg::TC_ADDR, 32'hFD, tsp_pkg::RESP_OKAY);
    // Let the write stall pass before the first edge
    repeat (8) @(posedge aclk);
    u_src.pulses(4, 2, 2);
    repeat (12) @(posedge aclk);
    rd(tsp_pkg::TC_ADDR, ok(8'h01));
    u_src.level(1'b1);
    repeat (12) @(posedge aclk);
    rd(tsp_pkg::TC_ADDR, ok(8'h02));
    u_src.level(1'b0);
    repeat (12) @(posedge aclk);
    rd(tsp_pkg::TC_ADDR, ok(8'h02));
    // Falling edges
    wr(tsp_pkg::SET_ADDR, 32'h38, tsp_pkg::RESP_OKAY);
    wr(tsp_pkg::TC_ADDR, 32'h10, tsp_pkg::RESP_OKAY);
    u_src.level(1'b1);
    repeat (12) @(posedge aclk);
    rd(tsp_pkg::TC_ADDR, ok(8'h10));
    u_src.level(1'b0);
    repeat (12) @(posedge aclk);
    rd(tsp_pkg::TC_ADDR, ok(8'h11));
    // Divider to timer at 1:4, cleared by a count write
    n0 = n_clr;
    wr(tsp_pkg::CMD_ADDR, 32'h1, tsp_pkg::RESP_OKAY);
    wr(tsp_pkg::SET_ADDR, 32'h21, tsp_pkg::RESP_OKAY);
    chk_val("clear pulses", 34'h1, 34'(n_clr - n0));
    u_src.pulses(3, 3, 6);
    wr(tsp_pkg::TC_ADDR, 32'h20, tsp_pkg::RESP_OKAY);
    u_src.pulses(2, 3, 6);
    repeat (12) @(posedge aclk);
    rd(tsp_pkg::TC_ADDR, ok(8'h21));
    u_src.pulses(2, 3, 6);
    repeat (12) @(posedge aclk);
    rd(tsp_pkg::TC_ADDR, ok(8'h21));
    // Divider back to watchdog, then watchdog clear resets it
    wr(tsp_pkg::CMD_ADDR, 32'h1, tsp_pkg::RESP_OKAY);
    wr(tsp_pkg::TC_ADDR, 32'h0, tsp_pkg::RESP_OKAY);
    wr(tsp_pkg::SET_ADDR, 32'h2F, tsp_pkg::RESP_OKAY);
    wr(tsp_pkg::CMD_ADDR, 32'h1, tsp_pkg::RESP_OKAY);
    wr(tsp_pkg::SET_ADDR, 32'h2A, tsp_pkg::RESP_OKAY);
    n0 = n_tick;
    u_src.ticks(2);
    wr(tsp_pkg::CMD_ADDR, 32'h1, tsp_pkg::RESP_OKAY);
    u_src.ticks(2);
    repeat (4) @(posedge aclk);
    chk_val("wdt ticks", 34'h0, 34'(n_tick - n0));
    // Every watchdog ratio gives one tick per 2^ratio
    for (int r = 0; r < 8; r++)
    begin
      wr(tsp_pkg::SET_ADDR, 32'h28 | r, tsp_pkg::RESP_OKAY);
      wr(tsp_pkg::CMD_ADDR, 32'h1, tsp_pkg::RESP_OKAY);
      n0 = n_tick;
      u_src.ticks(1 << r);
      repeat (4) @(posedge aclk);
      chk_val("wdt ticks", 34'h1, 34'(n_tick - n0));
    end
    // Timer owns the divider, watchdog runs undivided
    wr(tsp_pkg::CMD_ADDR, 32'h1, tsp_pkg::RESP_OKAY);
    wr(tsp_pkg::SET_ADDR, 32'h27, tsp_pkg::RESP_OKAY);
    n0 = n_tick;
    u_src.ticks(3);
    repeat (4) @(posedge aclk);
    chk_val("wdt ticks", 34'h3, 34'(n_tick - n0));
    // Internal count through the divider at 1:4, cleared by the count write
    wr(tsp_pkg::SET_ADDR, 32'h01, tsp_pkg::RESP_OKAY);
    b = ((cyc + 1) / 4 + 2) * 4 + 3;
    at(b);
    wr(tsp_pkg::TC_ADDR, 32'h0, tsp_pkg::RESP_OKAY);
    at(b + 20);
    rd(tsp_pkg::TC_ADDR, ok(8'h01));
    at(b + 36);
    rd(tsp_pkg::TC_ADDR, ok(8'h02));
    end_of_test();
  end
endmodule : testbench
`default_nettype wire

// ---- testbench/tsp_src.sv ----
`timescale 1ns/1ps
`default_nettype none
module tsp_src (
  // Clock
  input  wire logic aclk,
  // Lines into the device
  output var  logic pin,
  output var  logic osc
);
  // Both lines idle low
  initial
  begin
    pin = 1'b0;
    osc = 1'b0;
  end

  // Change pin level just after an edge
  task automatic level(input logic v);
    @(posedge aclk);
    pin <= v;
  endtask : level

  // Pulse train, callers keep hi and lo at two clocks or more
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n)
    begin
      level(1'b1);
      repeat (hi - 1) @(posedge aclk);
      level(1'b0);
      repeat (lo - 1) @(posedge aclk);
    end
  endtask : pulses

  // One-clock oscillator ticks with gaps
  task automatic ticks(input int n);
    repeat (n)
    begin
      @(posedge aclk);
      osc <= ~osc;
      @(posedge aclk);
      osc <= ~osc;
      repeat (2) @(posedge aclk);
    end
  endtask : ticks
endmodule : tsp_src
`default_nettype wire
